// [sac_conversion_control.sv]
// control logic around an 8-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
module sac_conversion_control (
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	input  wire logic [sac_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [7:0]                regWdata,
	input  wire logic                      regWr,
	input  wire logic                      regRd,
	output logic      [7:0]                regRdata,
	input  wire sac_pkg::sac_timer_s       timerEvt,
	input  wire logic                      extStartPin,
	input  wire logic                      sleepMode,
	input  wire logic                      sarCompare,
	output logic      [7:0]                sarTrial,
	output sac_pkg::sac_front_s            frontEnd,
	output logic                           convBusy,
	output logic                           convIrq
);

	// one-hot mask for a bit position
	function automatic logic [7:0] bitMask(input logic [2:0] idx);
		bitMask = 8'h01 << idx;
	endfunction

	// software-visible register state
	logic                ctrlEnable;   // converter on
	logic                trackMode;    // low-power tracking
	logic                doneFlag;     // sticky completion
	logic                irqEnable;    // interrupt gate
	logic [2:0]          startSrc;     // start source code
	logic [4:0]          clkDivide;    // conversion divider
	logic [1:0]          ampGain;      // amplifier gain
	logic [7:0]          muxSel;       // neg and pos select
	logic                next_ctrlEnable;
	logic                next_trackMode;
	logic                next_doneFlag;
	logic                next_irqEnable;
	logic [2:0]          next_startSrc;
	logic [4:0]          next_clkDivide;
	logic [1:0]          next_ampGain;
	logic [7:0]          next_muxSel;
	logic [7:0]          next_regRdata;

	// strobe synchroniser and filtered level
	logic                strbS1;       // metastability stage
	logic                strbS2;
	logic                strbS3;
	logic                strbLvl;      // agreed level
	logic                next_strbLvl;
	logic                extRise;      // filtered rising edge

	// sequencer state
	sac_pkg::sac_state_e state;
	sac_pkg::sac_state_e next_state;
	logic [4:0]          divCnt;       // divider phase
	logic [4:0]          next_divCnt;
	logic [1:0]          trkCnt;       // tracking clocks seen
	logic [1:0]          next_trkCnt;
	logic [2:0]          bitIdx;       // bit being decided
	logic [2:0]          next_bitIdx;
	logic [7:0]          next_sarTrial;
	logic [7:0]          convResult;   // formatted result
	logic [7:0]          next_convResult;

	// shared decode
	logic                diffMode;
	logic                convTick;     // one per conversion clock
	logic                swStart;
	logic                t2Ovf;
	logic                trigger;
	logic                startReq;
	logic                doneSet;      // conversion completes
	logic [7:0]          convRaw;      // trial after decision

	// field decode used by several groups
	always_comb
	begin
		// ground chosen whenever top negative bit set
		diffMode = ~muxSel[sac_pkg::MUX_NEG_LSB+3];
		convTick = (divCnt == clkDivide);
		// timer 2 half follows its counting width
		t2Ovf = timerEvt.t2Is16 ? timerEvt.t2HighOvf
			: timerEvt.t2LowOvf;
		swStart = regWr && (regAddr == sac_pkg::REG_CTRL)
			&& regWdata[sac_pkg::CTRL_BUSY];
		extRise = next_strbLvl && !strbLvl;
		// start source selection
		unique case (startSrc)
			sac_pkg::SRC_SW: trigger = swStart;
			sac_pkg::SRC_T0: trigger = timerEvt.t0Ovf;
			sac_pkg::SRC_T2: trigger = t2Ovf;
			sac_pkg::SRC_T1: trigger = timerEvt.t1Ovf;
			default:         trigger = extRise;
		endcase
		// triggers while busy or disabled are dropped
		startReq = ctrlEnable && (state == sac_pkg::ST_IDLE)
			&& trigger;
	end

	// strobe level: counts once stages two and three agree
	always_comb
	begin
		next_strbLvl = (strbS2 == strbS3) ? strbS3 : strbLvl;
	end

	// strobe flops; only stage two reads stage one
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			strbS1  <= 1'b0;
			strbS2  <= 1'b0;
			strbS3  <= 1'b0;
			strbLvl <= 1'b0;
		end
		else
		begin
			strbS1  <= extStartPin;
			strbS2  <= strbS1;
			strbS3  <= strbS2;
			strbLvl <= next_strbLvl;
		end
	end

	// sequencer, divider and approximation register
	always_comb
	begin
		next_state      = state;
		next_divCnt     = convTick ? 5'h00 : divCnt + 5'h01;
		next_trkCnt     = trkCnt;
		next_bitIdx     = bitIdx;
		next_sarTrial   = sarTrial;
		next_convResult = convResult;
		doneSet         = 1'b0;
		// keep the bit when the comparator says input is higher
		convRaw = sarCompare ? sarTrial
			: (sarTrial & ~bitMask(bitIdx));
		unique case (state)
			sac_pkg::ST_IDLE:
			begin
				if (startReq)
				begin
					// restart divider so each phase is a full clock
					next_divCnt = 5'h00;
					next_trkCnt = 2'h0;
					next_bitIdx = sac_pkg::SAR_TOP;
					next_sarTrial = sac_pkg::SAR_FIRST;
					// strobe already tracked while it was low
					if (trackMode && !startSrc[2])
						next_state = sac_pkg::ST_TRACK;
					else
						next_state = sac_pkg::ST_CONV;
				end
			end
			sac_pkg::ST_TRACK:
			begin
				if (convTick)
				begin
					next_trkCnt = trkCnt + 2'h1;
					if (trkCnt == sac_pkg::TRACK_CLKS - 2'h1)
						next_state = sac_pkg::ST_CONV;
				end
			end
			sac_pkg::ST_CONV:
			begin
				if (convTick)
				begin
					if (bitIdx == 3'h0)
					begin
						// last decision: publish and drop busy
						next_state = sac_pkg::ST_IDLE;
						doneSet    = 1'b1;
						next_sarTrial = convRaw;
						// offset binary becomes signed when differential
						next_convResult = diffMode
							? (convRaw ^ sac_pkg::SIGN_FLIP)
							: convRaw;
					end
					else
					begin
						next_bitIdx = bitIdx - 3'h1;
						next_sarTrial = convRaw
							| bitMask(bitIdx - 3'h1);
					end
				end
			end
			default:
				next_state = sac_pkg::ST_IDLE;
		endcase
		// disabling aborts silently and holds the divider at zero
		if (!ctrlEnable)
		begin
			next_state  = sac_pkg::ST_IDLE;
			next_divCnt = 5'h00;
			doneSet     = 1'b0;
		end
	end

	// sequencer flops
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state      <= sac_pkg::ST_IDLE;
			divCnt     <= 5'h00;
			trkCnt     <= 2'h0;
			bitIdx     <= 3'h0;
			sarTrial   <= 8'h00;
			convResult <= 8'h00;
		end
		else
		begin
			state      <= next_state;
			divCnt     <= next_divCnt;
			trkCnt     <= next_trkCnt;
			bitIdx     <= next_bitIdx;
			sarTrial   <= next_sarTrial;
			convResult <= next_convResult;
		end
	end

	// register writes, flag handling and read data
	always_comb
	begin
		next_ctrlEnable = ctrlEnable;
		next_trackMode  = trackMode;
		next_doneFlag   = doneFlag;
		next_irqEnable  = irqEnable;
		next_startSrc   = startSrc;
		next_clkDivide  = clkDivide;
		next_ampGain    = ampGain;
		next_muxSel     = muxSel;
		next_regRdata   = 8'h00;
		if (regWr)
		begin
			unique case (regAddr)
				sac_pkg::REG_CTRL:
				begin
					next_ctrlEnable = regWdata[sac_pkg::CTRL_EN];
					next_trackMode  = regWdata[sac_pkg::CTRL_TM];
					// writing zero clears, writing one leaves it
					next_doneFlag = doneFlag
						& regWdata[sac_pkg::CTRL_FLAG];
					next_irqEnable = regWdata[sac_pkg::CTRL_IRQEN];
					next_startSrc = regWdata[sac_pkg::CTRL_SRC_LSB
						+: sac_pkg::SRC_W];
				end
				sac_pkg::REG_CFG:
				begin
					next_clkDivide = regWdata[sac_pkg::CFG_DIV_LSB +: 5];
					next_ampGain = regWdata[sac_pkg::CFG_GAIN_LSB
						+: 2];
				end
				sac_pkg::REG_MUX:
					next_muxSel = regWdata;
				default:
					next_muxSel = muxSel; // result is read-only
			endcase
		end
		// completion beats a clear in the same cycle
		if (doneSet)
			next_doneFlag = 1'b1;
		if (regRd)
		begin
			unique case (regAddr)
				sac_pkg::REG_CTRL:
					next_regRdata = {ctrlEnable, trackMode, doneFlag,
						convBusy, irqEnable, startSrc};
				sac_pkg::REG_CFG:
					next_regRdata = {clkDivide, 1'b0, ampGain};
				sac_pkg::REG_MUX:
					next_regRdata = muxSel;
				default:
					next_regRdata = convResult;
			endcase
		end
	end

	// register flops
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrlEnable <= sac_pkg::CTRL_RST[sac_pkg::CTRL_EN];
			trackMode  <= sac_pkg::CTRL_RST[sac_pkg::CTRL_TM];
			doneFlag   <= sac_pkg::CTRL_RST[sac_pkg::CTRL_FLAG];
			irqEnable  <= sac_pkg::CTRL_RST[sac_pkg::CTRL_IRQEN];
			startSrc   <= sac_pkg::CTRL_RST[2:0];
			clkDivide  <= sac_pkg::DIV_RST;
			ampGain    <= sac_pkg::GAIN_RST;
			muxSel     <= sac_pkg::MUX_RST;
			regRdata   <= 8'h00;
		end
		else
		begin
			ctrlEnable <= next_ctrlEnable;
			trackMode  <= next_trackMode;
			doneFlag   <= next_doneFlag;
			irqEnable  <= next_irqEnable;
			startSrc   <= next_startSrc;
			clkDivide  <= next_clkDivide;
			ampGain    <= next_ampGain;
			muxSel     <= next_muxSel;
			regRdata   <= next_regRdata;
		end
	end

	// status and front-end steering, from flops except the sleepMode input
	always_comb
	begin
		convBusy = (state != sac_pkg::ST_IDLE);
		convIrq  = doneFlag && irqEnable;
		frontEnd.shutdown = !ctrlEnable;
		frontEnd.diffMode = diffMode;
		frontEnd.gain     = ampGain;
		frontEnd.posSel   = muxSel[sac_pkg::MUX_POS_LSB +: 4];
		frontEnd.negSel   = muxSel[sac_pkg::MUX_NEG_LSB +: 4];
		frontEnd.tempSel  = (frontEnd.posSel == sac_pkg::POS_TEMP);
		frontEnd.vddSel   = (frontEnd.posSel == sac_pkg::POS_VDD);
		// sleep forces tracking off in every mode to save the sampling current
		if (!ctrlEnable || sleepMode)
			frontEnd.track = 1'b0;
		else if (!trackMode)
			frontEnd.track = !convBusy;
		else if (startSrc[2])
			frontEnd.track = !convBusy && !strbLvl;
		else
			frontEnd.track = (state == sac_pkg::ST_TRACK);
	end

	// checks on the sequencer and registers
	sequence s_lastDecision;
		(state == sac_pkg::ST_CONV) && convTick && (bitIdx == 3'h0)
			&& ctrlEnable;
	endsequence

	sequence s_convFromTrack;
		(state == sac_pkg::ST_CONV) && ($past(state) == sac_pkg::ST_TRACK);
	endsequence

	property p_offStaysIdle;
		@(posedge sys_clk) disable iff (!rstn)
		!ctrlEnable |=> (state == sac_pkg::ST_IDLE) && !convBusy;
	endproperty
	a_offStaysIdle: assert property (p_offStaysIdle)
		else $error("converter busy while disabled");

	property p_unsignedCode;
		@(posedge sys_clk) disable iff (!rstn)
		s_lastDecision and !diffMode |=> convResult == $past(convRaw);
	endproperty
	a_unsignedCode: assert property (p_unsignedCode)
		else $error("single-ended result not unsigned");

	property p_signedCode;
		@(posedge sys_clk) disable iff (!rstn)
		s_lastDecision and diffMode
			|=> convResult == ($past(convRaw) ^ 8'h80);
	endproperty
	a_signedCode: assert property (p_signedCode)
		else $error("differential result not signed");

	property p_divTick;
		@(posedge sys_clk) disable iff (!rstn)
		(state == sac_pkg::ST_CONV) && convTick && ctrlEnable
			&& !$past(startReq) |-> $past(divCnt) == clkDivide - 5'h01
			|| clkDivide == 5'h00;
	endproperty
	a_divTick: assert property (p_divTick)
		else $error("conversion clock period wrong");

	property p_swStart;
		@(posedge sys_clk) disable iff (!rstn)
		swStart && startSrc == 3'h0 && ctrlEnable && !convBusy
			|=> convBusy;
	endproperty
	a_swStart: assert property (p_swStart)
		else $error("software start not taken");

	property p_extStart;
		@(posedge sys_clk) disable iff (!rstn)
		startSrc[2] && extRise && ctrlEnable && !convBusy
			|=> state == sac_pkg::ST_CONV;
	endproperty
	a_extStart: assert property (p_extStart)
		else $error("strobe edge did not start conversion");

	property p_doneOnFall;
		@(posedge sys_clk) disable iff (!rstn)
		s_lastDecision |=> !convBusy && doneFlag;
	endproperty
	a_doneOnFall: assert property (p_doneOnFall)
		else $error("busy fall without done flag");

	property p_trackThree;
		@(posedge sys_clk) disable iff (!rstn)
		s_convFromTrack |-> $past(trkCnt) == 2'h2;
	endproperty
	a_trackThree: assert property (p_trackThree)
		else $error("tracking period not three clocks");

	property p_bitOrder;
		@(posedge sys_clk) disable iff (!rstn)
		(state == sac_pkg::ST_CONV) && convTick && (bitIdx != 3'h0)
			&& ctrlEnable |=> bitIdx == $past(bitIdx) - 3'h1;
	endproperty
	a_bitOrder: assert property (p_bitOrder)
		else $error("bits not resolved msb first");

endmodule // sac_conversion_control
`default_nettype wire

// [sac_conversion_control_tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_conversion_control_tb;
	logic                sys_clk;     // system clock
	logic                rstn;        // async reset
	logic [1:0]          regAddr;     // register index
	logic [7:0]          regWdata;    // write data
	logic                regWr;       // write strobe
	logic                regRd;       // read strobe
	logic [7:0]          regRdata;    // read data
	sac_pkg::sac_timer_s timerEvt;    // timer pulses
	logic                extStartPin; // external start strobe
	logic                sleepMode;   // chip standby
	logic                sarCompare;  // comparator answer
	logic [7:0]          sarTrial;    // trial code
	sac_pkg::sac_front_s frontEnd;    // front end steering
	logic                convBusy;    // busy level
	logic                convIrq;     // interrupt level
	logic [7:0]          level;       // analog input as a code
	logic [7:0]          d;           // read scratch
	int                  n;           // busy cycles seen
	int                  error_cnt;   // mismatches
	int                  checks;      // comparisons

	sac_conversion_control u_sac_conversion_control (
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.regAddr     (regAddr),
		.regWdata    (regWdata),
		.regWr       (regWr),
		.regRd       (regRd),
		.regRdata    (regRdata),
		.timerEvt    (timerEvt),
		.extStartPin (extStartPin),
		.sleepMode   (sleepMode),
		.sarCompare  (sarCompare),
		.sarTrial    (sarTrial),
		.frontEnd    (frontEnd),
		.convBusy    (convBusy),
		.convIrq     (convIrq)
	);

	sac_front_model u_sac_front_model (
		.sys_clk    (sys_clk),
		.level      (level),
		.sarTrial   (sarTrial),
		.frontEnd   (frontEnd),
		.sarCompare (sarCompare)
	);

	// free-running 100 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// compare and count
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one-cycle register write
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask

	// read; data stand only in the cycle after the strobe
	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask

	// bounded wait for busy, then count its high cycles into n
	task waitConv(input int lim);
		int k;
		k = 0;
		n = 0;
		#1;
		while (convBusy !== 1'b1 && k < lim)
		begin
			@(posedge sys_clk);
			#1 k++;
		end
		while (convBusy === 1'b1 && n < 1000)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
	endtask

	task results();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// reset values of registers and front end
	task t_reset();
		rd(sac_pkg::REG_CTRL, d);
		chk(d, sac_pkg::CTRL_RST);
		rd(sac_pkg::REG_CFG, d);
		chk(d, {sac_pkg::DIV_RST, 1'b0, sac_pkg::GAIN_RST});
		rd(sac_pkg::REG_MUX, d);
		chk(d, sac_pkg::MUX_RST);
		chk(8'(frontEnd.shutdown), 8'h01);
		$display("reset test done");
	endtask

	// disabled start is dropped; clearing enable aborts
	task t_disabled();
		wr(sac_pkg::REG_CTRL, 8'h10);
		waitConv(5);
		chk(8'(n), 8'h00);
		wr(sac_pkg::REG_CFG, 8'hF8);
		// enable first; a start in the enabling write is dropped
		wr(sac_pkg::REG_CTRL, 8'h90);
		wr(sac_pkg::REG_CTRL, 8'h90);
		#1 chk(8'(convBusy), 8'h01);
		wr(sac_pkg::REG_CTRL, 8'h00);
		// abort lands one edge after enable drops
		@(posedge sys_clk);
		#1 chk(8'(convBusy), 8'h00);
		rd(sac_pkg::REG_CTRL, d);
		chk(d, 8'h00);
		$display("disable test done");
	endtask

	// one software conversion at divide 12, result checked
	task conv(input logic [7:0] lv, input logic [7:0] exp);
		level <= lv;
		repeat (4) @(posedge sys_clk);
		wr(sac_pkg::REG_CTRL, 8'h98);
		#1 chk(sarTrial, sac_pkg::SAR_FIRST);
		waitConv(3);
		chk(8'(n), 8'h68);
		rd(sac_pkg::REG_CTRL, d);
		chk(d, 8'hA8);
		chk(8'(convIrq), 8'h01);
		rd(sac_pkg::REG_RESULT, d);
		chk(d, exp);
	endtask

	// code formats, mux steering, gain, tracking levels
	task t_formats();
		int g;
		wr(sac_pkg::REG_CFG, 8'h60);
		wr(sac_pkg::REG_MUX, 8'hF0);
		#1 chk(8'(frontEnd.diffMode), 8'h00);
		chk(8'(frontEnd.track), 8'h00);
		wr(sac_pkg::REG_CTRL, 8'h88);
		#1 chk(8'(frontEnd.track), 8'h01);
		@(posedge sys_clk);
		sleepMode <= 1'b1;
		#1 chk(8'(frontEnd.track), 8'h00);
		@(posedge sys_clk);
		sleepMode <= 1'b0;
		#1 chk(8'(frontEnd.track), 8'h01);
		conv(8'h00, 8'h00);
		conv(8'hFF, 8'hFF);
		conv(8'hA5, 8'hA5);
		wr(sac_pkg::REG_RESULT, 8'h11);
		rd(sac_pkg::REG_RESULT, d);
		chk(d, 8'hA5);
		wr(sac_pkg::REG_CTRL, 8'h88);
		#1 chk(8'(convIrq), 8'h00);
		wr(sac_pkg::REG_MUX, 8'h78);
		#1 chk(8'(frontEnd.diffMode), 8'h01);
		chk(8'(frontEnd.tempSel), 8'h01);
		chk(8'(frontEnd.negSel), 8'h07);
		chk(8'(frontEnd.posSel), 8'h08);
		wr(sac_pkg::REG_MUX, 8'h09);
		#1 chk(8'(frontEnd.vddSel), 8'h01);
		conv(8'h00, 8'h80);
		conv(8'hFF, 8'h7F);
		conv(8'h30, 8'hB0);
		for (g = 0; g < 4; g++)
		begin
			wr(sac_pkg::REG_CFG, {sac_pkg::DIV_RST, 1'b0, 2'(g)});
			#1 chk(8'(frontEnd.gain), 8'(g));
		end
		$display("format test done");
	endtask

	// arm a source, fire a timer pulse or the pin, count busy
	task trig(input logic [2:0] s, input logic [4:0] ev,
		input logic pin, input logic [7:0] e);
		wr(sac_pkg::REG_CTRL, {5'h10, s});
		@(posedge sys_clk);
		timerEvt <= sac_pkg::sac_timer_s'(ev);
		extStartPin <= pin;
		@(posedge sys_clk);
		timerEvt <= sac_pkg::sac_timer_s'({4'h0, ev[0]});
		waitConv(8);
		chk(8'(n), e);
		chk(8'(convIrq), 8'h00);
		@(posedge sys_clk);
		extStartPin <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	task t_sources();
		trig(3'h1, 5'h10, 1'b0, 8'h68);
		trig(3'h1, 5'h08, 1'b0, 8'h00);
		trig(3'h2, 5'h04, 1'b0, 8'h68);
		trig(3'h2, 5'h03, 1'b0, 8'h68);
		trig(3'h2, 5'h05, 1'b0, 8'h00);
		trig(3'h3, 5'h08, 1'b0, 8'h68);
		trig(3'h3, 5'h10, 1'b0, 8'h00);
		trig(3'h4, 5'h00, 1'b1, 8'h68);
		trig(3'h7, 5'h00, 1'b1, 8'h68);
		trig(3'h1, 5'h00, 1'b1, 8'h00);
		$display("source test done");
	endtask

	// low-power tracking at divide 13
	task t_lowpower();
		// divide 13 keeps the conversion clock legal
		wr(sac_pkg::REG_CFG, 8'h68);
		wr(sac_pkg::REG_CTRL, 8'hC0);
		#1 chk(8'(frontEnd.track), 8'h00);
		wr(sac_pkg::REG_CTRL, 8'hD0);
		#1 chk(8'(frontEnd.track), 8'h01);
		waitConv(4);
		chk(8'(n), 8'h9A);
		wr(sac_pkg::REG_CTRL, 8'hC4);
		repeat (4) @(posedge sys_clk);
		#1 chk(8'(frontEnd.track), 8'h01);
		@(posedge sys_clk);
		extStartPin <= 1'b1;
		waitConv(8);
		chk(8'(n), 8'h70);
		chk(8'(frontEnd.track), 8'h00);
		@(posedge sys_clk);
		extStartPin <= 1'b0;
		$display("low-power test done");
	endtask

	// hang guard
	initial
	begin
		#100us;
		error_cnt++;
		results();
	end

	// main sequence
	initial
	begin
		error_cnt = 0;
		checks = 0;
		rstn = 1'b0;
		regAddr = 2'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		timerEvt = sac_pkg::sac_timer_s'(5'h00);
		extStartPin = 1'b0;
		sleepMode = 1'b0;
		level = 8'h00;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_disabled();
		t_formats();
		t_sources();
		t_lowpower();
		results();
	end
endmodule // sac_conversion_control_tb
`default_nettype wire

// [sac_front_model.sv]
// comparator model standing in for the analog front end
`timescale 1ns/1ps
`default_nettype none
module sac_front_model (
	input  wire logic                sys_clk,
	input  wire logic [7:0]          level,
	input  wire logic [7:0]          sarTrial,
	input  wire sac_pkg::sac_front_s frontEnd,
	output logic                     sarCompare
);
	// ideal comparator; raw code equals the level
	// powered down it wanders with the clock, never the last decision
	always_comb
	begin
		if (frontEnd.shutdown)
			sarCompare = sys_clk;
		else
			sarCompare = (level >= sarTrial);
	end
endmodule // sac_front_model
`default_nettype wire

// [sac_pkg.sv]
// constants, types and carriers for the converter control block
`default_nettype none
package sac_pkg;

	// system clock and derived conversion clock limits
	localparam int CLK_HZ          = 100_000_000;
	localparam int MAX_CONV_CLK_HZ = 8_300_000;
	localparam int MAX_RATE_SPS    = 500_000;
	// smallest divide value keeping the conversion clock legal
	localparam logic [4:0] DIV_RST =
		5'((CLK_HZ + MAX_CONV_CLK_HZ - 1) / MAX_CONV_CLK_HZ - 1);

	// register map, one byte per index
	localparam int         ADDR_W     = 2;
	localparam logic [1:0] REG_CTRL   = 2'h0;
	localparam logic [1:0] REG_CFG    = 2'h1;
	localparam logic [1:0] REG_MUX    = 2'h2;
	localparam logic [1:0] REG_RESULT = 2'h3;

	// control register fields
	localparam int CTRL_EN      = 7;
	localparam int CTRL_TM      = 6;
	localparam int CTRL_FLAG    = 5;
	localparam int CTRL_BUSY    = 4;
	localparam int CTRL_IRQEN   = 3;
	localparam int CTRL_SRC_LSB = 0;
	localparam int SRC_W        = 3;

	// configuration register fields
	localparam int CFG_DIV_LSB  = 3;
	localparam int CFG_GAIN_LSB = 0;

	// multiplexer register fields
	localparam int MUX_NEG_LSB = 4;
	localparam int MUX_POS_LSB = 0;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] GAIN_RST = 2'h0;
	localparam logic [7:0] MUX_RST  = 8'h00;

	// start source encodings, top bit set means external strobe
	localparam logic [2:0] SRC_SW = 3'h0;
	localparam logic [2:0] SRC_T0 = 3'h1;
	localparam logic [2:0] SRC_T2 = 3'h2;
	localparam logic [2:0] SRC_T1 = 3'h3;

	// internal positive inputs
	localparam logic [3:0] POS_TEMP = 4'h8;
	localparam logic [3:0] POS_VDD  = 4'h9;

	// sequencing counts
	localparam logic [1:0] TRACK_CLKS = 2'h3;
	localparam logic [2:0] SAR_TOP    = 3'h7;
	localparam logic [7:0] SAR_FIRST  = 8'h80;
	localparam logic [7:0] SIGN_FLIP  = 8'h80;

	// sequencer states, gray along idle, track, convert
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_TRACK = 2'h1,
		ST_CONV  = 2'h3
	} sac_state_e;

	// timer overflow pulses
	typedef struct packed {
		logic t0Ovf;
		logic t1Ovf;
		logic t2LowOvf;
		logic t2HighOvf;
		logic t2Is16;
	} sac_timer_s;

	// steering for the analog front end
	typedef struct packed {
		logic       shutdown;
		logic       track;
		logic       diffMode;
		logic [1:0] gain;
		logic [3:0] posSel;
		logic [3:0] negSel;
		logic       tempSel;
		logic       vddSel;
	} sac_front_s;

endpackage
`default_nettype wire
